// [ssp_spi_port.sv]
// What this block does
// - Full-duplex 8-bit words, all four clock modes
// - Shift register moves most significant bit first
// - Full byte goes to buffer, sets interrupt flag
// - Data write loads buffer and shift register
// - Shift register reachable only through data buffer
// - Master samples mid or end by sample-phase
// - Edge select picks which clock edge shifts out
// - Polarity bit sets serial clock idle level
// - Buffer full sets on receive, clears on read
// - Status low six read-only, top two writable
// - Write during transfer ignored, sets collision flag
// - Slave overrun sets overflow, drops new byte
// - Overflow never set by hardware in master mode
// - Enable bit hands pins to the port
// - Stop status cleared while port disabled
// - Mode field picks master rate or slave
// - Master write starts transfer immediately
// - High select releases data out, clears count
// - Reset disables port and ends transfer
//
// Chosen here: the Avalon-MM register port and the register offsets.
module ssp_spi_port
    import ssp_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic [3:0]   avs_address_i,
    input  wire logic         avs_read_i,
    input  wire logic         avs_write_i,
    input  wire logic [31:0]  avs_writedata_i,
    input  wire logic [3:0]   avs_byteenable_i,
    output logic      [31:0]  avs_readdata_o,
    output logic              avs_waitrequest_o,
    input  wire logic         period_timer_tick_i,
    input  wire ssp_pin_in_s  pins_i,
    output ssp_pin_out_s      pins_o,
    output logic              port_interrupt_flag_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ssp_pin_in_s  pin_s;          // Pins after synchronisation
    ssp_mstate_e  mst_reg;        // Master sequencer
    logic [7:0]   shreg_reg;      // serial_shift_register
    logic [7:0]   rx_buf_reg;     // serial_data_buffer
    logic [3:0]   cnt_reg;        // Bits sampled so far
    logic         out_bit_reg;    // Bit presented on data out
    logic         sck_prev_reg;   // Last synchronised clock level
    logic         smp_reg;        // input_sample_phase
    logic         cke_reg;        // Clock-edge select
    logic         bf_reg;         // buffer_full_flag
    logic         write_collision_flag_reg;       // write_collision_flag
    logic         ovf_reg;        // receive_overflow_flag
    logic         en_reg;         // port_enable_bit
    logic         ckp_reg;        // clock_idle_polarity
    logic [3:0]   mode_reg;       // port_mode_field
    logic         iflag_reg;      // port_interrupt_flag
    logic         rd_ack_reg;     // Read answer cycle
    logic [7:0]   rdata_reg;      // Read data held for the answer

    // ------------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------------
    logic       wr_any, wr_data, wr_ctl, wr_st, wr_if, rd_data;
    logic       is_master, is_slave, ss_high, busy, half_tick;
    logic       sck_moved, s_lead, s_trail, s_sample, s_shift;
    logic       m_mid, m_end, m_sample, sample, s_done, m_done, done;
    logic       keep_byte;
    logic [7:0] sh_in, rx_byte, wbyte;

    // Pins from the other party are foreign to clk_i
    ssp_sync #(.W(3)) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .async_i (pins_i),
        .sync_o  (pin_s)
    );

    // Bus decode: writes never wait, byte lane 0 carries the data
    assign wbyte   = avs_writedata_i[7:0];
    assign wr_any  = avs_write_i && avs_byteenable_i[0];
    assign wr_data = wr_any && (avs_address_i == SSP_OFF_DATA);
    assign wr_ctl  = wr_any && (avs_address_i == SSP_OFF_CONTROL);
    assign wr_st   = wr_any && (avs_address_i == SSP_OFF_STATUS);
    assign wr_if   = wr_any && (avs_address_i == SSP_OFF_IFLAG);
    assign rd_data = avs_read_i && rd_ack_reg
                     && (avs_address_i == SSP_OFF_DATA);

    // Mode decode; reserved codes leave the port enabled but inert
    assign is_master = en_reg && (mode_reg[3:2] == 2'h0);
    assign is_slave  = en_reg && ((mode_reg == SSP_MODE_SL_SS)
                       || (mode_reg == SSP_MODE_SL_NSS));
    assign ss_high   = en_reg && (mode_reg == SSP_MODE_SL_SS)
                       && pin_s.slave_select_n;
    assign busy      = (mst_reg != SSP_M_IDLE) || (cnt_reg != 4'h0);

    ssp_rate_gen u_rate (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .run_i        (mst_reg != SSP_M_IDLE),
        .rate_i       (mode_reg[1:0]),
        .timer_tick_i (period_timer_tick_i),
        .half_tick_o  (half_tick)
    );

    // ------------------------------------------------------------------
    // Edge finding and sample points
    // ------------------------------------------------------------------
    // Leading edge leaves idle, trailing edge returns to idle
    assign sck_moved = is_slave && !ss_high && (pin_s.sck != sck_prev_reg);
    assign s_lead    = sck_moved && (pin_s.sck != ckp_reg);
    assign s_trail   = sck_moved && (pin_s.sck == ckp_reg);
    // Data shifts out on the edge picked by cke, samples on the other
    assign s_shift   = cke_reg ? s_trail : s_lead;
    assign s_sample  = cke_reg ? s_lead : s_trail;
    // Master sample sits mid-bit or at the end of the bit
    // At the fastest rate the input lag is half a bit, so the mid point
    // lands on the far side's change there: pick end sampling instead
    assign m_mid     = (mst_reg == SSP_M_FIRST) && half_tick;
    assign m_end     = (mst_reg == SSP_M_SECND) && half_tick;
    assign m_sample  = smp_reg ? m_end : m_mid;
    assign sample    = s_sample || m_sample;
    assign sh_in     = {shreg_reg[6:0], pin_s.sdi};
    assign s_done    = s_sample && (cnt_reg == SSP_BITS - 4'h1);
    assign m_done    = m_end && (smp_reg ? (cnt_reg == SSP_BITS - 4'h1)
                                         : (cnt_reg == SSP_BITS));
    assign done      = s_done || m_done;
    assign rx_byte   = sample ? sh_in : shreg_reg;
    // Slave overrun drops the byte; master always keeps it
    assign keep_byte = done && !(s_done && bf_reg);

    // Synchronised clock history for edge finding
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            sck_prev_reg <= 1'b0;
        else
            sck_prev_reg <= pin_s.sck;
    end

    // ------------------------------------------------------------------
    // Master sequencer: two halves per bit
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            mst_reg <= SSP_M_IDLE;
        else if (!is_master)
            mst_reg <= SSP_M_IDLE;
        else
        begin
            unique case (mst_reg)
                SSP_M_IDLE:
                    if (wr_data && !busy)
                        mst_reg <= SSP_M_FIRST;
                SSP_M_FIRST:
                    if (half_tick)
                        mst_reg <= SSP_M_SECND;
                SSP_M_SECND:
                    if (m_done)
                        mst_reg <= SSP_M_IDLE;
                    else if (half_tick)
                        mst_reg <= SSP_M_FIRST;
                default:
                    mst_reg <= SSP_M_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Shift path and bit count
    // ------------------------------------------------------------------
    // Only a data-buffer write reaches the shift register
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            shreg_reg <= SSP_DATA_RST;
        else if (wr_data && !busy)
            shreg_reg <= wbyte;
        else if (sample)
            shreg_reg <= sh_in;
    end

    // Data out changes at bit start, msb first
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            out_bit_reg <= 1'b0;
        else if (wr_data && !busy)
            out_bit_reg <= wbyte[7];
        else if (s_shift)
            out_bit_reg <= shreg_reg[7];
        else if (m_end)
            out_bit_reg <= smp_reg ? shreg_reg[6] : shreg_reg[7];
    end

    // Counter restarts on disable, raised select, or a full word
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            cnt_reg <= 4'h0;
        else if (!en_reg || ss_high)
            cnt_reg <= 4'h0;
        else if (done)
            cnt_reg <= 4'h0;
        else if (sample)
            cnt_reg <= cnt_reg + 4'h1;
    end

    // ------------------------------------------------------------------
    // Receive buffer and flags; a hardware set beats a clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            rx_buf_reg <= SSP_DATA_RST;
        else if (keep_byte)
            rx_buf_reg <= rx_byte;
        else if (wr_data && !busy)
            rx_buf_reg <= wbyte;
    end

    // Buffer full: set by a kept byte, cleared by reading the buffer
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            bf_reg <= 1'b0;
        else if (keep_byte)
            bf_reg <= 1'b1;
        else if (rd_data)
            bf_reg <= 1'b0;
    end

    // Interrupt flag: any finished word; write one to clear
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            iflag_reg <= 1'b0;
        else if (done)
            iflag_reg <= 1'b1;
        else if (wr_if && wbyte[SSP_IF_FLAG])
            iflag_reg <= 1'b0;
    end

    // Control register; collision and overflow are set by hardware
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            write_collision_flag_reg <= SSP_CONTROL_RST[SSP_CT_WRITE_COLLISION_FLAG];
            ovf_reg  <= SSP_CONTROL_RST[SSP_CT_OVF];
            en_reg   <= SSP_CONTROL_RST[SSP_CT_EN];
            ckp_reg  <= SSP_CONTROL_RST[SSP_CT_CKP];
            mode_reg <= SSP_CONTROL_RST[3:0];
        end
        else
        begin
            if (wr_ctl)
            begin
                en_reg   <= wbyte[SSP_CT_EN];
                ckp_reg  <= wbyte[SSP_CT_CKP];
                mode_reg <= wbyte[3:0];
            end
            if (wr_data && busy)
                write_collision_flag_reg <= 1'b1;
            else if (wr_ctl)
                write_collision_flag_reg <= wbyte[SSP_CT_WRITE_COLLISION_FLAG];
            if (s_done && bf_reg)
                ovf_reg <= 1'b1;
            else if (wr_ctl)
                ovf_reg <= wbyte[SSP_CT_OVF];
        end
    end

    // Status: only the top two bits take writes
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            smp_reg <= SSP_STATUS_RST[SSP_ST_SMP];
            cke_reg <= SSP_STATUS_RST[SSP_ST_CKE];
        end
        else if (wr_st)
        begin
            smp_reg <= wbyte[SSP_ST_SMP];
            cke_reg <= wbyte[SSP_ST_CKE];
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM read: one wait cycle, then registered data
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rd_ack_reg <= 1'b0;
            rdata_reg  <= 8'h00;
        end
        else
        begin
            rd_ack_reg <= avs_read_i && !rd_ack_reg;
            unique case (avs_address_i)
                // Stop status stays clear: SPI never sets it
                SSP_OFF_STATUS:  rdata_reg <= {smp_reg, cke_reg, 5'h00,
                                               bf_reg};
                SSP_OFF_CONTROL: rdata_reg <= {write_collision_flag_reg, ovf_reg, en_reg,
                                               ckp_reg, mode_reg};
                SSP_OFF_DATA:    rdata_reg <= rx_buf_reg;
                SSP_OFF_IFLAG:   rdata_reg <= {7'h00, iflag_reg};
                default:         rdata_reg <= 8'h00;
            endcase
        end
    end

    assign avs_waitrequest_o     = avs_read_i && !rd_ack_reg;
    assign avs_readdata_o        = {24'h000000, rdata_reg};
    assign port_interrupt_flag_o = iflag_reg;

    // ------------------------------------------------------------------
    // Pins: clock follows state flops; released when disabled
    // ------------------------------------------------------------------
    assign pins_o.sck    = ckp_reg ^ ((mst_reg == SSP_M_FIRST) ? !cke_reg
                         : (mst_reg == SSP_M_SECND) && cke_reg);
    assign pins_o.sck_oe = is_master;
    assign pins_o.sdo    = out_bit_reg;
    assign pins_o.sdo_oe = is_master || (is_slave && !ss_high);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence seq_idle_write;
        wr_data && !busy;
    endsequence

    a_collision_flag: assert property (
        wr_data && busy |=> write_collision_flag_reg && shreg_reg == $past(rx_byte))
        else $error("collision write not flagged");
    a_master_start: assert property (
        seq_idle_write ##0 is_master |=> mst_reg == SSP_M_FIRST)
        else $error("master write did not start");
    a_write_loads: assert property (
        seq_idle_write |=> shreg_reg == $past(wbyte)
                           && rx_buf_reg == $past(wbyte))
        else $error("data write not loaded");
    a_byte_kept: assert property (
        keep_byte |=> bf_reg && iflag_reg && rx_buf_reg == $past(rx_byte))
        else $error("received byte not kept");
    a_bf_read: assert property (
        rd_data && !keep_byte |=> !bf_reg)
        else $error("buffer full not cleared by read");
    a_slave_overrun: assert property (
        s_done && bf_reg |=> ovf_reg && $stable(rx_buf_reg))
        else $error("overrun not handled");
    a_master_no_ovf: assert property (
        is_master && !wr_ctl && !ovf_reg |=> !ovf_reg)
        else $error("overflow set in master mode");
    a_sck_idle: assert property (
        is_master && mst_reg == SSP_M_IDLE |-> pins_o.sck == ckp_reg)
        else $error("clock not at idle level");
    a_select_release: assert property (
        ss_high |-> !pins_o.sdo_oe ##1 cnt_reg == 4'h0)
        else $error("select high did not release");
    a_disable_clear: assert property (
        !en_reg |=> cnt_reg == 4'h0 && mst_reg == SSP_M_IDLE)
        else $error("disable left transfer state");

endmodule

// [ssp_pkg.sv]
package ssp_pkg;

    // ------------------------------------------------------------------
    // Register map, byte addresses on the Avalon-MM slave
    // ------------------------------------------------------------------
    localparam logic [3:0] SSP_OFF_STATUS  = 4'h0;  // serial_port_status
    localparam logic [3:0] SSP_OFF_CONTROL = 4'h4;  // serial_port_control_one
    localparam logic [3:0] SSP_OFF_DATA    = 4'h8;  // serial_data_buffer
    localparam logic [3:0] SSP_OFF_IFLAG   = 4'hC;  // port_interrupt_flag

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned SSP_ST_SMP   = 7;  // input_sample_phase
    localparam int unsigned SSP_ST_CKE   = 6;  // clock-edge select
    localparam int unsigned SSP_ST_STOP  = 4;  // stop-condition status
    localparam int unsigned SSP_ST_BF    = 0;  // buffer_full_flag
    localparam int unsigned SSP_CT_WRITE_COLLISION_FLAG  = 7;  // write_collision_flag
    localparam int unsigned SSP_CT_OVF   = 6;  // receive_overflow_flag
    localparam int unsigned SSP_CT_EN    = 5;  // port_enable_bit
    localparam int unsigned SSP_CT_CKP   = 4;  // clock_idle_polarity
    localparam int unsigned SSP_IF_FLAG  = 0;  // port_interrupt_flag

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] SSP_STATUS_RST  = 8'h00;
    localparam logic [7:0] SSP_CONTROL_RST = 8'h00;
    localparam logic [7:0] SSP_DATA_RST    = 8'h00;

    // ------------------------------------------------------------------
    // port_mode_field codes
    // ------------------------------------------------------------------
    localparam logic [3:0] SSP_MODE_DIV4   = 4'h0;  // Master, osc/4
    localparam logic [3:0] SSP_MODE_DIV16  = 4'h1;  // Master, osc/16
    localparam logic [3:0] SSP_MODE_DIV64  = 4'h2;  // Master, osc/64
    localparam logic [3:0] SSP_MODE_TIMER  = 4'h3;  // Master, timer/2
    localparam logic [3:0] SSP_MODE_SL_SS  = 4'h4;  // Slave, select used
    localparam logic [3:0] SSP_MODE_SL_NSS = 4'h5;  // Slave, no select

    // ------------------------------------------------------------------
    // Counts: half a serial clock period in oscillator cycles, and bits per word
    // ------------------------------------------------------------------
    localparam logic [5:0] SSP_HALF_DIV4  = 6'h02;
    localparam logic [5:0] SSP_HALF_DIV16 = 6'h08;
    localparam logic [5:0] SSP_HALF_DIV64 = 6'h20;
    localparam logic [3:0] SSP_BITS       = 4'h8;   // Bits per word

    // ------------------------------------------------------------------
    // Pin carriers and master sequencer states
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sck;             // serial_clock_pin level
        logic sdi;             // serial_data_in_pin level
        logic slave_select_n;  // slave_select_pin, active low
    } ssp_pin_in_s;

    typedef struct packed {
        logic sck;     // serial_clock_pin drive value
        logic sck_oe;  // High while the port drives the clock
        logic sdo;     // serial_data_out_pin drive value
        logic sdo_oe;  // High while the port drives data out
    } ssp_pin_out_s;

    typedef enum logic [2:0] {
        SSP_M_IDLE  = 3'b001,
        SSP_M_FIRST = 3'b010,
        SSP_M_SECND = 3'b100
    } ssp_mstate_e;

endpackage

// [ssp_sync.sv]
// ----------------------------------------------------------------------
// Two flip-flop synchroniser, one stage pair per bit
// ----------------------------------------------------------------------
module ssp_sync
    import ssp_pkg::*;
#(
    parameter int unsigned W = 3
)(
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    generate
        for (genvar i = 0; i < W; i++)
        begin : g_bit
            logic meta_reg;  // First stage, read only by the second

            // Metastability filter for one pin
            always_ff @(posedge clk_i or posedge reset_i)
            begin
                if (reset_i)
                begin
                    meta_reg  <= 1'b0;
                    sync_o[i] <= 1'b0;
                end
                else
                begin
                    meta_reg  <= async_i[i];
                    sync_o[i] <= meta_reg;
                end
            end
        end
    endgenerate

endmodule

// [ssp_rate_gen.sv]
// ----------------------------------------------------------------------
// Master bit-rate divider: one-cycle pulse per serial half period
// ----------------------------------------------------------------------
module ssp_rate_gen
    import ssp_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       run_i,         // Master transfer active
    input  wire logic [1:0] rate_i,        // Low bits of the mode
    input  wire logic       timer_tick_i,  // period_timer_output pulse
    output logic            half_tick_o
);

    logic [5:0] div_reg;  // Cycles spent in this half period
    logic [5:0] limit;    // Half period length for the chosen rate

    // Rate select; the timer source needs no counting of its own
    always_comb
    begin
        unique case (rate_i)
            2'h0:    limit = SSP_HALF_DIV4;
            2'h1:    limit = SSP_HALF_DIV16;
            default: limit = SSP_HALF_DIV64;
        endcase
    end

    // Restart on every idle spell so each byte opens with a full half
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            div_reg <= 6'h00;
        else if (!run_i || half_tick_o)
            div_reg <= 6'h00;
        else
            div_reg <= div_reg + 6'h01;
    end

    // Two timer pulses make one serial period
    assign half_tick_o = run_i && ((rate_i == SSP_MODE_TIMER[1:0])
                         ? timer_tick_i : (div_reg == limit - 6'h01));

endmodule

// [ssp_slave_model.sv]
// ----------------------------------------------------------------------
// Far-side slave: reply byte out, master byte captured
// ----------------------------------------------------------------------
module ssp_slave_model #(
    parameter logic [7:0] TX = 8'h3C  // Reply byte
)(
    input  wire logic       sck_i,
    input  wire logic       sdo_i,
    output logic            sdi_o,
    output logic [7:0]      rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh_reg = TX;  // Msb is on the line before the first edge
    logic       last = 1'b0;  // Last known clock level
    // Capture on rising, change on falling, as edge select set asks;
    // only moves between known levels count, so the clock settling
    // out of reset is not taken for an edge
    always @(sck_i)
    begin
        if (last === 1'b0 && sck_i === 1'b1)
            rx_o <= {rx_o[6:0], sdo_i};
        // Fill with a toggling bit so a late sample never looks valid
        if (last === 1'b1 && sck_i === 1'b0)
            sh_reg <= {sh_reg[6:0], ~sh_reg[0]};
        last = sck_i;
    end
    assign sdi_o = sh_reg[7];
endmodule

// [ssp_spi_port_tb.sv]
// ----------------------------------------------------------------------
// Bench: register traffic and two master bytes
// ----------------------------------------------------------------------
module ssp_spi_port_tb
    import ssp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, reset_i = 1, avs_read_i = 0, avs_write_i = 0;
    logic [3:0] avs_address_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
    logic avs_waitrequest_o, port_interrupt_flag_o, sdi;
    ssp_pin_out_s pins_o;
    logic [7:0] q, rx;
    int err_count = 0, checks = 0, n;
    ssp_spi_port i_dut (.clk_i(clk_i), .reset_i(reset_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .period_timer_tick_i(1'b0), .pins_i({pins_o.sck, sdi, 1'b1}),
        .pins_o(pins_o), .port_interrupt_flag_o(port_interrupt_flag_o));
    ssp_slave_model i_slave (.sck_i(pins_o.sck), .sdo_i(pins_o.sdo),
        .sdi_o(sdi), .rx_o(rx));
    initial forever #4 clk_i = ~clk_i;
    task results();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // One bus cycle, held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int t;
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= w;
        avs_read_i <= ~w;
        for (t = 0; t < 20; t++)
        begin
            @(posedge clk_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        if (t == 20)
        begin
            err_count++;
            results();
        end
        q = avs_readdata_o[7:0];
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rd(input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    // Poll the interrupt flag, bounded, until a word completes
    task wait_flag();
        q = 8'h00;
        for (n = 0; n < 100 && q !== 8'h01; n++)
            bus(1'b0, SSP_OFF_IFLAG, 8'h00);
        chk(q, 8'h01);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rd(SSP_OFF_STATUS, 8'h00);
        rd(SSP_OFF_CONTROL, 8'h00);
        rd(4'h2, 8'h00);
        bus(1'b1, SSP_OFF_STATUS, 8'hFF);
        rd(SSP_OFF_STATUS, 8'hC0);
        chk(pins_o.sck_oe, 1'b0);
        // Word one: fastest rate, sampled at the end of each bit
        bus(1'b1, SSP_OFF_CONTROL, 8'h20);
        chk(pins_o.sck_oe, 1'b1);
        bus(1'b1, SSP_OFF_DATA, 8'hA5);
        bus(1'b1, SSP_OFF_DATA, 8'hFF);
        wait_flag();
        chk(pins_o.sck, 1'b0);
        rd(SSP_OFF_CONTROL, 8'hA0);
        rd(SSP_OFF_STATUS, 8'hC1);
        rd(SSP_OFF_DATA, 8'h3C);
        rd(SSP_OFF_STATUS, 8'hC0);
        chk(rx, 8'hA5);
        bus(1'b1, SSP_OFF_IFLAG, 8'h01);
        rd(SSP_OFF_IFLAG, 8'h00);
        // Word two: sixteen-cycle rate, sampled mid-bit
        bus(1'b1, SSP_OFF_STATUS, 8'h40);
        bus(1'b1, SSP_OFF_CONTROL, 8'h21);
        rd(SSP_OFF_CONTROL, 8'h21);
        bus(1'b1, SSP_OFF_DATA, 8'h5A);
        wait_flag();
        rd(SSP_OFF_DATA, 8'hAA);
        chk(rx, 8'h5A);
        // Slave modes, then master idle clock with polarity set: the select pin is tied high at the bench
        bus(1'b1, SSP_OFF_CONTROL, 8'h24);
        chk(pins_o.sdo_oe, 1'b0);
        chk(pins_o.sck_oe, 1'b0);
        bus(1'b1, SSP_OFF_CONTROL, 8'h25);
        chk(pins_o.sdo_oe, 1'b1);
        bus(1'b1, SSP_OFF_CONTROL, 8'h30);
        chk(pins_o.sck, 1'b1);
        results();
    end
endmodule
